// ---- verilog/mpfs_pkg.sv ----
// package: register map, field layout and carriers of the pin select bank
package mpfs_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ONE   = 8'h10;
  localparam logic [7:0] IDX_TWO   = 8'h11;
  localparam logic [7:0] IDX_THREE = 8'h12;
  localparam logic [7:0] IDX_FOUR  = 8'h13;
  localparam logic [7:0] IDX_QUICK = 8'h14;
  localparam logic [7:0] IDX_CTRL  = 8'h15;

  // reset values
  localparam logic [7:0] RST_ONE   = 8'h7F;
  localparam logic [7:0] RST_TWO   = 8'hCE;
  localparam logic [7:0] RST_THREE = 8'h42;
  localparam logic [7:0] RST_FOUR  = 8'hFC;
  localparam logic [7:0] RST_QUICK = 8'h01;

  // writable bits; reserved bits stay zero
  localparam logic [7:0] WMASK_THREE = 8'hFE;
  localparam logic [7:0] WMASK_FOUR  = 8'hFC;
  localparam logic [7:0] WMASK_QUICK = 8'h1F;

  // field positions, register one
  localparam int P1_PIN7 = 0, P1_PIN4 = 1, P1_PIN3 = 2, P1_PIN2 = 3;
  localparam int P1_PIN1 = 4, P1_DIODE3 = 5, P1_DIODE1 = 6, P1_VID = 7;
  // register two
  localparam int P2_PIN23 = 0, P2_PIN22 = 2, P2_PIN21 = 3, P2_PIN19 = 4;
  localparam int P2_PIN15 = 5, P2_PIN13 = 6, P2_PIN8 = 7;
  // register three
  localparam int P3_PIN27 = 1, P3_PIN26 = 2, P3_PIN25 = 4, P3_PIN24 = 6;
  // register four
  localparam int P4_PIN32 = 2, P4_PIN31 = 3, P4_PIN29 = 4, P4_PIN28 = 6;
  // control register
  localparam int PC_LOCK = 0, PC_SRST = 1;

  localparam logic [1:0] SEL_V15 = 2'h1;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } mpfs_ahb_req_t;

  typedef struct packed {
    logic       voltage_id_inputs;
    logic       fan_speed_input_5;
    logic [3:0] pin4_1_fan_speed;
    logic       remote_diode_3_pair;
    logic       remote_diode_1_pair;
    logic [1:0] pin23_range;
    logic       fan_speed_input_8;
    logic       fan_speed_input_7;
    logic       fan_speed_input_6;
    logic       pin19_low_range;
    logic       pin15_low_range;
    logic       fan_drive_output_4;
    logic       pin27_intrusion;
    logic [1:0] pin26_sel;
    logic [1:0] pin25_sel;
    logic [1:0] pin24_range;
    logic       fan_drive_output_2;
    logic       fan_drive_output_1;
    logic [1:0] pin29_sel;
    logic [1:0] pin28_sel;
    logic       v15_monitor_pair;
    logic [4:0] quick_option;
  } mpfs_pins_t;

  typedef struct packed {
    logic [7:0]  sel_one;
    logic [7:0]  sel_two;
    logic [7:0]  sel_three;
    logic [7:0]  sel_four;
    logic [7:0]  quick;
    logic        lock;
    logic        dp_wr;
    logic [7:0]  dp_idx;
    logic        ready;
    logic        resp;
    logic [31:0] hrdata;
    mpfs_pins_t  pins;
  } mpfs_state_t;

endpackage : mpfs_pkg

// ---- verilog/mpfs_pin_select.sv ----
// monitor pin function select bank with AHB-Lite register slave
`timescale 1ns/10ps
`default_nettype none
module mpfs_pin_select
  import mpfs_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_sys_rst,
  input  wire mpfs_ahb_req_t i_ahb,
  output logic [31:0]        o_hrdata,
  output logic               o_hreadyout,
  output logic               o_hresp,
  output mpfs_pins_t         o_pins
);

  function automatic mpfs_pins_t decode(input mpfs_state_t st);
    mpfs_pins_t p;
    logic       vid;
    vid = st.sel_one[P1_VID];
    p.voltage_id_inputs   = vid;
    p.fan_speed_input_5   = st.sel_one[P1_PIN7];
    p.pin4_1_fan_speed    = {st.sel_one[P1_PIN4], st.sel_one[P1_PIN3],
                             st.sel_one[P1_PIN2], st.sel_one[P1_PIN1]}
                            & {4{~vid}};
    p.remote_diode_3_pair = st.sel_one[P1_DIODE3];
    p.remote_diode_1_pair = st.sel_one[P1_DIODE1];
    p.pin23_range         = st.sel_two[P2_PIN23 +: 2];
    p.fan_speed_input_8   = st.sel_two[P2_PIN22];
    p.fan_speed_input_7   = st.sel_two[P2_PIN21];
    p.fan_speed_input_6   = st.sel_two[P2_PIN8];
    p.pin19_low_range     = st.sel_two[P2_PIN19]
                            & ~st.sel_one[P1_DIODE3];
    p.pin15_low_range     = st.sel_two[P2_PIN15]
                            & ~st.sel_one[P1_DIODE1];
    p.fan_drive_output_4  = st.sel_two[P2_PIN13];
    p.pin27_intrusion     = st.sel_three[P3_PIN27];
    p.pin26_sel           = st.sel_three[P3_PIN26 +: 2];
    p.pin25_sel           = st.sel_three[P3_PIN25 +: 2];
    p.pin24_range         = st.sel_three[P3_PIN24 +: 2];
    p.fan_drive_output_2  = st.sel_four[P4_PIN32] & ~vid;
    p.fan_drive_output_1  = st.sel_four[P4_PIN31] & ~vid;
    p.pin29_sel           = st.sel_four[P4_PIN29 +: 2];
    p.pin28_sel           = st.sel_four[P4_PIN28 +: 2];
    // 1.5 V only measured when both pins ask for it
    p.v15_monitor_pair    = (p.pin29_sel == SEL_V15)
                            && (p.pin28_sel == SEL_V15) && !vid;
    p.quick_option        = st.quick[4:0];
    return p;
  endfunction : decode

  function automatic mpfs_state_t rst_state();
    mpfs_state_t st;
    st           = '0;
    st.sel_one   = RST_ONE;
    st.sel_two   = RST_TWO;
    st.sel_three = RST_THREE;
    st.sel_four  = RST_FOUR;
    st.quick     = RST_QUICK;
    st.ready     = 1'b1;
    st.pins      = decode(st);
    return st;
  endfunction : rst_state

  function automatic logic [7:0] rd_byte(input mpfs_state_t st,
                                         input logic [7:0]  idx);
    logic [7:0] d;
    d = 8'h00;
    if (idx == IDX_ONE) begin
      d = st.sel_one;
    end else if (idx == IDX_TWO) begin
      d = st.sel_two;
    end else if (idx == IDX_THREE) begin
      d = st.sel_three;
    end else if (idx == IDX_FOUR) begin
      d = st.sel_four;
    end else if (idx == IDX_QUICK) begin
      d = st.quick;
    end else if (idx == IDX_CTRL) begin
      d = {7'h00, st.lock};
    end
    return d;
  endfunction : rd_byte

  localparam mpfs_state_t ST_RST = rst_state();

  mpfs_state_t s_r;
  mpfs_state_t s_nxt;
  logic        take;
  logic        mapped;
  logic [7:0]  wd;
  logic [7:0]  aidx;

  always_comb begin
    s_nxt  = s_r;
    wd     = i_ahb.hwdata[7:0];
    aidx   = i_ahb.haddr[9:2];
    mapped = (i_ahb.haddr[31:10] == 22'h0);
    take   = i_ahb.hsel && i_ahb.htrans[1] && s_r.ready;
    // data phase of a write
    if (s_r.dp_wr) begin
      if (s_r.dp_idx == IDX_CTRL) begin
        if (wd[PC_SRST]) begin
          s_nxt.sel_one   = RST_ONE;
          s_nxt.sel_two   = RST_TWO;
          s_nxt.sel_three = RST_THREE;
          s_nxt.sel_four  = RST_FOUR;
          s_nxt.quick     = RST_QUICK;
        end
        if (wd[PC_LOCK]) begin
          s_nxt.lock = 1'b1;
        end
      end else if (!s_r.lock) begin
        if (s_r.dp_idx == IDX_ONE) begin
          s_nxt.sel_one = wd;
        end else if (s_r.dp_idx == IDX_TWO) begin
          s_nxt.sel_two = wd;
        end else if (s_r.dp_idx == IDX_THREE) begin
          s_nxt.sel_three = wd & WMASK_THREE;
        end else if (s_r.dp_idx == IDX_FOUR) begin
          s_nxt.sel_four = wd & WMASK_FOUR;
        end else if (s_r.dp_idx == IDX_QUICK) begin
          s_nxt.quick = wd & WMASK_QUICK;
        end
      end
    end
    // address phase
    s_nxt.dp_wr  = take && i_ahb.hwrite && mapped;
    s_nxt.dp_idx = aidx;
    if (take && !i_ahb.hwrite) begin
      // read sees a write finishing in this same cycle
      s_nxt.hrdata = {24'h0, mapped ? rd_byte(s_nxt, aidx) : 8'h00};
    end
    s_nxt.ready = 1'b1;
    s_nxt.resp  = 1'b0;
    s_nxt.pins  = decode(s_nxt);
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_hrdata    = s_r.hrdata;
  assign o_hreadyout = s_r.ready;
  assign o_hresp     = s_r.resp;
  assign o_pins      = s_r.pins;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  logic wr_ctrl;
  assign wr_ctrl = s_r.dp_wr && (s_r.dp_idx == IDX_CTRL);

  chk_pin7_fan_route: assert property (
    o_pins.fan_speed_input_5 == s_r.sel_one[P1_PIN7])
    else $error("pin 7 route differs from its select bit");

  chk_gpio_fan_sel: assert property (
    !s_r.sel_one[P1_VID] |-> o_pins.pin4_1_fan_speed ==
      {s_r.sel_one[P1_PIN4], s_r.sel_one[P1_PIN3],
       s_r.sel_one[P1_PIN2], s_r.sel_one[P1_PIN1]})
    else $error("pins 4..1 fan select wrong");

  chk_vid_override: assert property (
    o_pins.voltage_id_inputs |-> o_pins.pin4_1_fan_speed == 4'h0
      && !o_pins.fan_drive_output_2 && !o_pins.fan_drive_output_1)
    else $error("voltage-ID enable did not override pins");

  chk_diode3_range: assert property (
    o_pins.remote_diode_3_pair |-> !o_pins.pin19_low_range)
    else $error("pin 19 range active with diode three");

  chk_diode1_range: assert property (
    o_pins.remote_diode_1_pair |-> !o_pins.pin15_low_range)
    else $error("pin 15 range active with diode one");

  chk_reg_two_write: assert property (
    s_r.dp_wr && !s_r.lock && s_r.dp_idx == IDX_TWO
      |=> s_r.sel_two == $past(i_ahb.hwdata[7:0])
        && o_pins.fan_speed_input_8 == $past(i_ahb.hwdata[P2_PIN22]))
    else $error("register two write did not land");

  chk_lock_refuse: assert property (
    s_r.lock && s_r.dp_wr && s_r.dp_idx != IDX_CTRL
      |=> $stable({s_r.sel_one, s_r.sel_two, s_r.sel_three,
                   s_r.sel_four, s_r.quick}))
    else $error("write accepted while locked");

  chk_soft_reset: assert property (
    wr_ctrl && i_ahb.hwdata[PC_SRST]
      |=> s_r.sel_one == RST_ONE && s_r.sel_two == RST_TWO
        && s_r.sel_three == RST_THREE && s_r.sel_four == RST_FOUR
        && s_r.quick == RST_QUICK)
    else $error("software reset did not restore defaults");

  chk_reserved_zero: assert property (
    s_r.sel_three[0] == 1'b0 && s_r.sel_four[1:0] == 2'h0
      && s_r.quick[7:5] == 3'h0)
    else $error("reserved bit became set");

  chk_read_upper: assert property (
    take && !i_ahb.hwrite |=> o_hrdata[31:8] == 24'h0 && o_hreadyout)
    else $error("read data upper bits not zero");

  chk_diode3_enable: assert property (
    o_pins.remote_diode_3_pair == s_r.sel_one[P1_DIODE3])
    else $error("diode three enable differs from its bit");

  chk_diode1_enable: assert property (
    o_pins.remote_diode_1_pair == s_r.sel_one[P1_DIODE1])
    else $error("diode one enable differs from its bit");

  chk_pin23_range: assert property (
    o_pins.pin23_range == s_r.sel_two[P2_PIN23 +: 2])
    else $error("pin 23 range differs from its field");

  chk_monitor_fan_sel: assert property (
    o_pins.fan_speed_input_8 == s_r.sel_two[P2_PIN22]
      && o_pins.fan_speed_input_7 == s_r.sel_two[P2_PIN21]
      && o_pins.fan_speed_input_6 == s_r.sel_two[P2_PIN8])
    else $error("pins 22, 21, 8 fan select wrong");

  chk_pin19_range: assert property (
    !o_pins.remote_diode_3_pair
      |-> o_pins.pin19_low_range == s_r.sel_two[P2_PIN19])
    else $error("pin 19 range ignores its bit");

  chk_pin15_range: assert property (
    !o_pins.remote_diode_1_pair
      |-> o_pins.pin15_low_range == s_r.sel_two[P2_PIN15])
    else $error("pin 15 range ignores its bit");

  chk_pin13_drive: assert property (
    o_pins.fan_drive_output_4 == s_r.sel_two[P2_PIN13])
    else $error("pin 13 drive select wrong");

  chk_pin27_intrusion: assert property (
    o_pins.pin27_intrusion == s_r.sel_three[P3_PIN27])
    else $error("pin 27 function select wrong");

  chk_pin26_sel: assert property (
    o_pins.pin26_sel == s_r.sel_three[P3_PIN26 +: 2])
    else $error("pin 26 select differs from its field");

  chk_pin25_sel: assert property (
    o_pins.pin25_sel == s_r.sel_three[P3_PIN25 +: 2])
    else $error("pin 25 select differs from its field");

  chk_pin24_range: assert property (
    o_pins.pin24_range == s_r.sel_three[P3_PIN24 +: 2])
    else $error("pin 24 range differs from its field");

  chk_pin32_drive: assert property (
    !o_pins.voltage_id_inputs
      |-> o_pins.fan_drive_output_2 == s_r.sel_four[P4_PIN32])
    else $error("pin 32 drive select wrong");

  chk_pin31_drive: assert property (
    !o_pins.voltage_id_inputs
      |-> o_pins.fan_drive_output_1 == s_r.sel_four[P4_PIN31])
    else $error("pin 31 drive select wrong");

  chk_pin29_sel: assert property (
    o_pins.pin29_sel == s_r.sel_four[P4_PIN29 +: 2])
    else $error("pin 29 select differs from its field");

  chk_pin28_sel: assert property (
    o_pins.pin28_sel == s_r.sel_four[P4_PIN28 +: 2])
    else $error("pin 28 select differs from its field");

  chk_v15_pair_flag: assert property (
    o_pins.v15_monitor_pair |-> o_pins.pin29_sel == SEL_V15
      && o_pins.pin28_sel == SEL_V15 && !o_pins.voltage_id_inputs)
    else $error("1.5 V pair flag without both selects");

  chk_quick_option: assert property (
    o_pins.quick_option == s_r.quick[4:0])
    else $error("quick option pins differ from register");

  chk_reg_one_write: assert property (
    s_r.dp_wr && !s_r.lock && s_r.dp_idx == IDX_ONE
      |=> s_r.sel_one == $past(i_ahb.hwdata[7:0]))
    else $error("register one write did not land");

  chk_reg_three_mask: assert property (
    s_r.dp_wr && !s_r.lock && s_r.dp_idx == IDX_THREE
      |=> s_r.sel_three == ($past(i_ahb.hwdata[7:0]) & WMASK_THREE))
    else $error("register three write wrong");

  chk_reg_four_mask: assert property (
    s_r.dp_wr && !s_r.lock && s_r.dp_idx == IDX_FOUR
      |=> s_r.sel_four == ($past(i_ahb.hwdata[7:0]) & WMASK_FOUR))
    else $error("register four write wrong");

  chk_quick_mask: assert property (
    s_r.dp_wr && !s_r.lock && s_r.dp_idx == IDX_QUICK
      |=> s_r.quick == ($past(i_ahb.hwdata[7:0]) & WMASK_QUICK))
    else $error("quick register write wrong");

  chk_lock_set: assert property (
    wr_ctrl && i_ahb.hwdata[PC_LOCK] |=> s_r.lock)
    else $error("lock write did not set lock");

  chk_lock_sticky: assert property (
    s_r.lock |=> s_r.lock)
    else $error("lock cleared without reset");

  chk_pins_hold: assert property (
    !s_r.dp_wr |=> $stable(o_pins))
    else $error("pins changed outside a write");

  chk_bus_okay: assert property (
    o_hreadyout && !o_hresp)
    else $error("slave not ready or not okay");

  chk_unmapped_zero: assert property (
    take && !i_ahb.hwrite && !mapped |=> o_hrdata == 32'h0)
    else $error("unmapped read returned data");

  chk_ctrl_read: assert property (
    take && !i_ahb.hwrite && mapped && aidx == IDX_CTRL
      |=> o_hrdata == {31'h0, s_r.lock})
    else $error("control read does not show lock");

  chk_reg_one_read: assert property (
    take && !i_ahb.hwrite && mapped && aidx == IDX_ONE
      |=> o_hrdata == {24'h0, s_r.sel_one})
    else $error("register one read wrong");

  chk_reg_four_read: assert property (
    take && !i_ahb.hwrite && mapped && aidx == IDX_FOUR
      |=> o_hrdata == {24'h0, s_r.sel_four})
    else $error("register four read wrong");

  chk_idle_ignored: assert property (
    !take |=> !s_r.dp_wr)
    else $error("write phase without a taken request");

  chk_reset_defaults: assert property (
    @(posedge i_clk) disable iff (1'b0)
    i_sys_rst |-> s_r.sel_one == RST_ONE && s_r.sel_two == RST_TWO
      && s_r.sel_three == RST_THREE && s_r.sel_four == RST_FOUR
      && s_r.quick == RST_QUICK && !s_r.lock)
    else $error("reset did not restore defaults");

  cov_locked_write: cover property (
    s_r.lock && s_r.dp_wr && s_r.dp_idx == IDX_ONE);
  cov_soft_reset: cover property (wr_ctrl && i_ahb.hwdata[PC_SRST]);
  cov_vid_on: cover property (o_pins.voltage_id_inputs);
  cov_v15_pair: cover property (o_pins.v15_monitor_pair);
  cov_unmapped_read: cover property (take && !i_ahb.hwrite && !mapped);

endmodule : mpfs_pin_select
`default_nettype wire

// ---- bench/test_mpfs_pin_select.sv ----
// self-checking bench for the pin function select bank
`timescale 1ns/10ps
`default_nettype none
module test_mpfs_pin_select;
  import mpfs_pkg::*;
  logic          i_clk;
  logic          i_sys_rst;
  mpfs_ahb_req_t req;
  logic [31:0]   o_hrdata;
  logic          o_hreadyout;
  logic          o_hresp;
  mpfs_pins_t    o_pins;
  logic [7:0]    m [5];
  logic [31:0]   rd;
  int            fail_count;
  int            n_tests;
  // rows: index, write data, read-back
  logic [47:0]   rows [16] = '{
    {IDX_ONE, 32'h80, 8'h80}, {IDX_ONE, 32'h0, 8'h0},
    {IDX_TWO, 32'h31, 8'h31}, {IDX_TWO, 32'h3, 8'h3},
    {IDX_TWO, 32'h0, 8'h0}, {IDX_THREE, 32'hFF, 8'hFE},
    {IDX_THREE, 32'h95, 8'h94}, {IDX_THREE, 32'h28, 8'h28},
    {IDX_FOUR, 32'h57, 8'h54}, {IDX_FOUR, 32'h0B, 8'h08},
    {IDX_FOUR, 32'hA0, 8'hA0}, {IDX_QUICK, 32'hFF, 8'h1F},
    {IDX_QUICK, 32'h10, 8'h10}, {8'h20, 32'hAA, 8'h0},
    {IDX_ONE, 32'hABCDEF7F, 8'h7F}, {IDX_ONE, 32'h9E, 8'h9E}};

  mpfs_pin_select u_mpfs_pin_select (
    .i_clk       (i_clk),
    .i_sys_rst   (i_sys_rst),
    .i_ahb       (req),
    .o_hrdata    (o_hrdata),
    .o_hreadyout (o_hreadyout),
    .o_hresp     (o_hresp),
    .o_pins      (o_pins)
  );

  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  task automatic close_out();
    $display("compares %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_hreadyout !== 1'b1 && n < 20);
    if (o_hreadyout !== 1'b1) begin
      fail_count++;
      close_out();
    end
  endtask : wait_rdy

  task automatic xfer_at(input logic [31:0] addr, input logic wr,
                         input logic [31:0] wd);
    req.hsel   <= 1'b1;
    req.haddr  <= addr;
    req.htrans <= 2'h2;
    req.hwrite <= wr;
    req.hsize  <= 3'h2;
    wait_rdy();
    req.htrans <= 2'h0;
    req.hsel   <= 1'b0;
    req.hwdata <= wd;
    wait_rdy();
    rd = o_hrdata;
    check(64'(o_hresp), 64'h0);
  endtask : xfer_at

  task automatic xfer(input logic [7:0] idx, input logic wr,
                      input logic [31:0] wd);
    xfer_at({22'h0, idx, 2'h0}, wr, wd);
  endtask : xfer

  function automatic mpfs_pins_t pexp();
    mpfs_pins_t p;
    logic       v;
    v = m[0][7];
    p.voltage_id_inputs   = v;
    p.fan_speed_input_5   = m[0][0];
    p.pin4_1_fan_speed    = {m[0][1], m[0][2], m[0][3], m[0][4]} & {4{~v}};
    p.remote_diode_3_pair = m[0][5];
    p.remote_diode_1_pair = m[0][6];
    p.pin23_range         = m[1][1:0];
    p.fan_speed_input_8   = m[1][2];
    p.fan_speed_input_7   = m[1][3];
    p.fan_speed_input_6   = m[1][7];
    p.pin19_low_range     = m[1][4] & ~m[0][5];
    p.pin15_low_range     = m[1][5] & ~m[0][6];
    p.fan_drive_output_4  = m[1][6];
    p.pin27_intrusion     = m[2][1];
    p.pin26_sel           = m[2][3:2];
    p.pin25_sel           = m[2][5:4];
    p.pin24_range         = m[2][7:6];
    p.fan_drive_output_2  = m[3][2] & ~v;
    p.fan_drive_output_1  = m[3][3] & ~v;
    p.pin29_sel           = m[3][5:4];
    p.pin28_sel           = m[3][7:6];
    p.v15_monitor_pair    = m[3][5:4] == 2'h1 && m[3][7:6] == 2'h1 && !v;
    p.quick_option        = m[4][4:0];
    return p;
  endfunction : pexp

  // reads the five bank registers and the pins against the model
  task automatic check_all();
    for (int k = 0; k < 5; k++) begin
      xfer(IDX_ONE + 8'(k), 1'b0, 32'h0);
      check(64'(rd), 64'(m[k]));
    end
    check(64'(o_pins), 64'(pexp()));
  endtask : check_all

  task automatic do_reset();
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    m = '{RST_ONE, RST_TWO, RST_THREE, RST_FOUR, RST_QUICK};
    @(posedge i_clk);
  endtask : do_reset

  initial begin
    i_sys_rst  = 1'b0;
    req        = '0;
    fail_count = 0;
    n_tests    = 0;
    do_reset();
    check_all();
    $display("test reset values done");
    xfer(IDX_CTRL, 1'b0, 32'h0);
    check(64'(rd), 64'h0);
    // alias with upper address bits set must not reach register one
    xfer_at(32'h440, 1'b1, 32'h0);
    xfer_at(32'h440, 1'b0, 32'h0);
    check(64'(rd), 64'h0);
    check_all();
    $display("test unmapped alias done");
    foreach (rows[r]) begin
      // pairs of 1.5 V selects are always written together
      xfer(rows[r][47:40], 1'b1, rows[r][39:8]);
      if (rows[r][47:40] >= IDX_ONE && rows[r][47:40] <= IDX_QUICK)
        m[rows[r][47:40] - IDX_ONE] = rows[r][7:0];
      xfer(rows[r][47:40], 1'b0, 32'h0);
      check(64'(rd), 64'(rows[r][7:0]));
      check(64'(o_pins), 64'(pexp()));
    end
    $display("test table done");
    xfer(IDX_CTRL, 1'b1, 32'h1);
    xfer(IDX_TWO, 1'b1, 32'h55);
    xfer(IDX_QUICK, 1'b1, 32'h4);
    xfer(IDX_CTRL, 1'b0, 32'h0);
    check(64'(rd), 64'h1);
    check_all();
    $display("test lock done");
    xfer(IDX_CTRL, 1'b1, 32'h2);
    m = '{RST_ONE, RST_TWO, RST_THREE, RST_FOUR, RST_QUICK};
    check_all();
    xfer(IDX_CTRL, 1'b0, 32'h0);
    check(64'(rd), 64'h1);
    $display("test software reset done");
    xfer(IDX_FOUR, 1'b1, 32'h0);
    do_reset();
    check_all();
    xfer(IDX_CTRL, 1'b0, 32'h0);
    check(64'(rd), 64'h0);
    xfer(IDX_FOUR, 1'b1, 32'h57);
    m[3] = 8'h54;
    check_all();
    $display("test mid-run reset done");
    close_out();
  end
endmodule : test_mpfs_pin_select
`default_nettype wire
